// ===== hdl/clocked_fifo_4k_x9.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_map.svh"

// Functional notes
// - Hold 4096 nine-bit words, first in first out
// - Write needs both write enables high on edge
// - Read updates output only when both enables high
// - Reset low clears both pointers and flags
// - Full flag low while buffer holds maximum
// - Half flag low while above half capacity
// - Near flag low within eight of boundary
// - Empty flag low while no unread words
// - Output enable low drives data, else undriven
// - Port strobes need no mutual relation
// - Ports interact only at full or empty
// - Controls and flags follow own port strobe
// - Half flag tells near-empty from near-full
// - Parallel devices act as one wider buffer
// - No interlock: overrun overwrites, underrun rereads
// - Flags show empty after reset
// - Output register zero until first read
// - Flags change only on enabled operations or a device reset
module clocked_fifo_4k_x9 #(
    parameter int DEPTH = 4096,
    parameter int WIDTH = 9
) (
    // System clock and bus reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Device reset pin
    input  wire logic             reset_low,
    // Write port
    input  wire logic             write_clock,
    input  wire logic             write_enable_a,
    input  wire logic             write_enable_b,
    input  wire logic [WIDTH-1:0] write_data,
    // Read port
    input  wire logic             read_clock,
    input  wire logic             read_enable_a,
    input  wire logic             read_enable_b,
    input  wire logic             output_enable_low,
    output logic      [WIDTH-1:0] read_data,
    output logic                  read_data_drive_low,
    // Status flags
    output var fifo_pkg::flags_t  flags,
    // AXI4-Lite write address and data
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    import fifo_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_COUNT = CW'(DEPTH / 2);
    localparam logic [CW-1:0] NEAR_LOW   = CW'(`NEAR_MARGIN);
    localparam logic [CW-1:0] NEAR_HIGH  = CW'(DEPTH - `NEAR_MARGIN);

    // Strobe history for edge detection
    logic             wclk_prev_r, wclk_prev_nxt;
    logic             rclk_prev_r, rclk_prev_nxt;
    // Pointers, occupancy and flags
    logic [AW-1:0]    wptr_r, wptr_nxt;
    logic [AW-1:0]    rptr_r, rptr_nxt;
    logic [CW-1:0]    count_r, count_nxt;
    flags_t           flags_r, flags_nxt;
    // Output register path
    logic             rd_pend_r, rd_pend_nxt;
    logic [WIDTH-1:0] rdata_q_r, rdata_q_nxt;
    logic             drive_low_r, drive_low_nxt;
    logic [WIDTH-1:0] mem_q;
    // Sticky misuse record
    logic [`ERR_W-1:0] err_r, err_nxt;
    logic [`ERR_W-1:0] err_set, err_w1c;
    // Software clear pulse
    logic             clear_pulse_r, clear_pulse_nxt;
    // Decoded port operations
    logic             wr_fire, rd_fire, clear;
    // AXI write side
    wr_state_t        wr_state_r, wr_state_nxt;
    logic             aw_have_r, aw_have_nxt;
    logic             w_have_r, w_have_nxt;
    logic [31:0]      awaddr_r, awaddr_nxt;
    logic [31:0]      wdata_r, wdata_nxt;
    logic [3:0]       wstrb_r, wstrb_nxt;
    logic             awready_r, awready_nxt;
    logic             wready_r, wready_nxt;
    logic             bvalid_r, bvalid_nxt;
    logic [1:0]       bresp_r, bresp_nxt;
    // AXI read side
    rd_state_t        rd_state_r, rd_state_nxt;
    logic             arready_r, arready_nxt;
    logic             rvalid_r, rvalid_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic [1:0]       rresp_r, rresp_nxt;

    // Port strobes are sampled as plain inputs; a rising edge with both enables is an op
    always_comb begin
        wclk_prev_nxt = write_clock;
        rclk_prev_nxt = read_clock;
        clear   = ~reset_low | clear_pulse_r;
        wr_fire = write_clock & ~wclk_prev_r
                & write_enable_a & write_enable_b;
        rd_fire = read_clock & ~rclk_prev_r
                & read_enable_a & read_enable_b;
    end

    // Pointers move on their own port only; count ties the two sides
    always_comb begin
        wptr_nxt  = wptr_r;
        rptr_nxt  = rptr_r;
        count_nxt = count_r;
        err_set   = '0;
        if (clear) begin
            // Device reset returns to the first location
            wptr_nxt  = '0;
            rptr_nxt  = '0;
            count_nxt = '0;
        end else begin
            if (wr_fire) begin
                wptr_nxt = wptr_r + AW'(1);
            end
            if (rd_fire) begin
                rptr_nxt = rptr_r + AW'(1);
            end
            case ({wr_fire, rd_fire})
                2'b10: begin
                    // Writing past full overwrites the oldest word
                    if (count_r == FULL_COUNT) begin
                        err_set[`ERR_OVERRUN_BIT] = 1'b1;
                    end else begin
                        count_nxt = count_r + CW'(1);
                    end
                end
                2'b01: begin
                    // Reading past empty rereads stale data
                    if (count_r == '0) begin
                        err_set[`ERR_UNDERRUN_BIT] = 1'b1;
                    end else begin
                        count_nxt = count_r - CW'(1);
                    end
                end
                2'b11: begin
                    // Both together leave occupancy unchanged
                    if (count_r == '0) begin
                        err_set[`ERR_UNDERRUN_BIT] = 1'b1;
                    end
                end
                default: begin
                    count_nxt = count_r;
                end
            endcase
        end
        // Flags decode from occupancy alone, so paralleled parts agree
        flags_nxt.full_low          = (count_nxt != FULL_COUNT);
        flags_nxt.half_low          = ~(count_nxt > HALF_COUNT);
        flags_nxt.near_boundary_low = ~((count_nxt < NEAR_LOW)
                                      | (count_nxt > NEAR_HIGH));
        flags_nxt.empty_low         = (count_nxt != '0);
    end

    // Output register loads a word only after an enabled read
    always_comb begin
        rd_pend_nxt   = rd_fire & ~clear;
        rdata_q_nxt   = rdata_q_r;
        drive_low_nxt = output_enable_low;
        if (clear) begin
            rdata_q_nxt = '0;
        end else if (rd_pend_r) begin
            rdata_q_nxt = mem_q;
        end
    end

    // Sticky misuse bits; a new event beats a simultaneous clear
    always_comb begin
        err_nxt = (err_r & ~err_w1c) | err_set;
    end

    // Port-side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wclk_prev_r <= 1'b1;
            rclk_prev_r <= 1'b1;
            wptr_r      <= '0;
            rptr_r      <= '0;
            count_r     <= '0;
            flags_r     <= `FLAGS_RESET;
            rd_pend_r   <= 1'b0;
            rdata_q_r   <= '0;
            drive_low_r <= 1'b1;
            err_r       <= '0;
        end else begin
            wclk_prev_r <= wclk_prev_nxt;
            rclk_prev_r <= rclk_prev_nxt;
            wptr_r      <= wptr_nxt;
            rptr_r      <= rptr_nxt;
            count_r     <= count_nxt;
            flags_r     <= flags_nxt;
            rd_pend_r   <= rd_pend_nxt;
            rdata_q_r   <= rdata_q_nxt;
            drive_low_r <= drive_low_nxt;
            err_r       <= err_nxt;
        end
    end

    // Word storage
    fifo_mem #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk     (aclk),
        .wr_en   (wr_fire & ~clear),
        .wr_addr (wptr_r),
        .wr_data (write_data),
        .rd_en   (rd_fire & ~clear),
        .rd_addr (rptr_r),
        .rd_data (mem_q)
    );

    // AXI write: address and data in either order, then one response
    always_comb begin
        wr_state_nxt    = wr_state_r;
        aw_have_nxt     = aw_have_r;
        w_have_nxt      = w_have_r;
        awaddr_nxt      = awaddr_r;
        wdata_nxt       = wdata_r;
        wstrb_nxt       = wstrb_r;
        bvalid_nxt      = bvalid_r;
        bresp_nxt       = bresp_r;
        clear_pulse_nxt = 1'b0;
        err_w1c         = '0;
        case (wr_state_r)
            WR_IDLE: begin
                // Capture each channel once
                if (s_axi_awvalid && awready_r) begin
                    aw_have_nxt = 1'b1;
                    awaddr_nxt  = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_r) begin
                    w_have_nxt = 1'b1;
                    wdata_nxt  = s_axi_wdata;
                    wstrb_nxt  = s_axi_wstrb;
                end
                // Both present: perform the write
                if (aw_have_nxt && w_have_nxt) begin
                    aw_have_nxt  = 1'b0;
                    w_have_nxt   = 1'b0;
                    bvalid_nxt   = 1'b1;
                    bresp_nxt    = `RESP_OKAY;
                    wr_state_nxt = WR_RESP;
                    if (awaddr_nxt == `OFS_CTRL) begin
                        // Software clear acts as a device reset
                        clear_pulse_nxt = wstrb_nxt[0] & wdata_nxt[`CTRL_CLEAR_BIT];
                    end else if (awaddr_nxt == `OFS_ERROR) begin
                        // Write one to clear misuse bits
                        if (wstrb_nxt[0]) begin
                            err_w1c = wdata_nxt[`ERR_W-1:0];
                        end
                    end else if (awaddr_nxt != `OFS_STATUS) begin
                        // Unmapped address
                        bresp_nxt = `RESP_SLVERR;
                    end
                end
            end
            WR_RESP: begin
                // Hold response until accepted
                if (s_axi_bready) begin
                    bvalid_nxt   = 1'b0;
                    wr_state_nxt = WR_IDLE;
                end
            end
            default: begin
                wr_state_nxt = WR_IDLE;
            end
        endcase
        awready_nxt = (wr_state_nxt == WR_IDLE) && !aw_have_nxt;
        wready_nxt  = (wr_state_nxt == WR_IDLE) && !w_have_nxt;
    end

    // AXI read: one beat per address, status built from live state
    always_comb begin
        logic [31:0] status;
        status         = '0;
        status[`STAT_FLAGS_LSB +: 4]  = flags_r;
        status[`STAT_COUNT_LSB +: CW] = count_r;
        rd_state_nxt   = rd_state_r;
        rvalid_nxt     = rvalid_r;
        rdata_nxt      = rdata_r;
        rresp_nxt      = rresp_r;
        case (rd_state_r)
            RD_IDLE: begin
                // Take address and decode
                if (s_axi_arvalid && arready_r) begin
                    rvalid_nxt   = 1'b1;
                    rresp_nxt    = `RESP_OKAY;
                    rd_state_nxt = RD_DATA;
                    if (s_axi_araddr == `OFS_STATUS) begin
                        rdata_nxt = status;
                    end else if (s_axi_araddr == `OFS_ERROR) begin
                        rdata_nxt = 32'(err_r);
                    end else if (s_axi_araddr == `OFS_CTRL) begin
                        rdata_nxt = '0;
                    end else begin
                        rdata_nxt = '0;
                        rresp_nxt = `RESP_SLVERR;
                    end
                end
            end
            RD_DATA: begin
                // Hold data until accepted
                if (s_axi_rready) begin
                    rvalid_nxt   = 1'b0;
                    rd_state_nxt = RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = RD_IDLE;
            end
        endcase
        arready_nxt = (rd_state_nxt == RD_IDLE);
    end

    // Bus-side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r    <= WR_IDLE;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            awready_r     <= 1'b1;
            wready_r      <= 1'b1;
            bvalid_r      <= 1'b0;
            bresp_r       <= `RESP_OKAY;
            clear_pulse_r <= 1'b0;
            rd_state_r    <= RD_IDLE;
            arready_r     <= 1'b1;
            rvalid_r      <= 1'b0;
            rdata_r       <= '0;
            rresp_r       <= `RESP_OKAY;
        end else begin
            wr_state_r    <= wr_state_nxt;
            aw_have_r     <= aw_have_nxt;
            w_have_r      <= w_have_nxt;
            awaddr_r      <= awaddr_nxt;
            wdata_r       <= wdata_nxt;
            wstrb_r       <= wstrb_nxt;
            awready_r     <= awready_nxt;
            wready_r      <= wready_nxt;
            bvalid_r      <= bvalid_nxt;
            bresp_r       <= bresp_nxt;
            clear_pulse_r <= clear_pulse_nxt;
            rd_state_r    <= rd_state_nxt;
            arready_r     <= arready_nxt;
            rvalid_r      <= rvalid_nxt;
            rdata_r       <= rdata_nxt;
            rresp_r       <= rresp_nxt;
        end
    end

    // Outputs straight from flops
    assign read_data           = rdata_q_r;
    assign read_data_drive_low = drive_low_r;
    assign flags               = flags_r;
    assign s_axi_awready       = awready_r;
    assign s_axi_wready        = wready_r;
    assign s_axi_bvalid        = bvalid_r;
    assign s_axi_bresp         = bresp_r;
    assign s_axi_arready       = arready_r;
    assign s_axi_rvalid        = rvalid_r;
    assign s_axi_rdata         = rdata_r;
    assign s_axi_rresp         = rresp_r;

    // Checks on the port behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_count_bound;
        count_r <= FULL_COUNT;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("count above depth");

    property p_write_count;
        wr_fire && !rd_fire && !clear && count_r != FULL_COUNT |=> count_r == $past(count_r) + CW'(1);
    endproperty
    a_write_count: assert property (p_write_count) else $error("write not taken");

    property p_read_hold;
        !rd_fire && !clear ##1 !clear |=> $stable(read_data);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("output moved without read");

    property p_clear;
        !reset_low |=> count_r == '0 && wptr_r == '0 && rptr_r == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("reset left pointers");

    property p_full;
        flags.full_low == (count_r != FULL_COUNT);
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");

    property p_half;
        flags.half_low == (count_r <= HALF_COUNT);
    endproperty
    a_half: assert property (p_half) else $error("half flag wrong");

    property p_near;
        !flags.near_boundary_low |-> (flags.half_low ? count_r < NEAR_LOW : count_r > NEAR_HIGH);
    endproperty
    a_near: assert property (p_near) else $error("near flag wrong");

    property p_empty;
        flags.empty_low == (count_r != '0);
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");

    property p_hiz;
        output_enable_low |=> read_data_drive_low;
    endproperty
    a_hiz: assert property (p_hiz) else $error("driving while disabled");

    property p_read_only;
        rd_fire && !wr_fire && !clear |=> $stable(wptr_r);
    endproperty
    a_read_only: assert property (p_read_only) else $error("read moved write side");

    property p_overrun;
        wr_fire && !rd_fire && !clear && count_r == FULL_COUNT |=> err_r[`ERR_OVERRUN_BIT] && count_r == FULL_COUNT;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not recorded");

    property p_reset_view;
        !reset_low |=> flags == `FLAGS_RESET && read_data == '0;
    endproperty
    a_reset_view: assert property (p_reset_view) else $error("reset view wrong");

    property p_flags_quiet;
        !wr_fire && !rd_fire && !clear |=> $stable(flags);
    endproperty
    a_flags_quiet: assert property (p_flags_quiet) else $error("flag moved idle");

    c_fill: cover property (count_r == FULL_COUNT);
    c_half: cover property ($fell(flags.half_low));
    c_drain: cover property ($fell(flags.empty_low) ##[1:1000] $rose(flags.empty_low));
    c_underrun: cover property ($rose(err_r[`ERR_UNDERRUN_BIT]));

endmodule

`default_nettype wire

// ===== hdl/fifo_map.svh
`ifndef FIFO_MAP_SVH
`define FIFO_MAP_SVH

// Register byte offsets on the AXI4-Lite slave
`define OFS_CTRL          32'h0000_0000
`define OFS_STATUS        32'h0000_0004
`define OFS_ERROR         32'h0000_0008

// Control register fields
`define CTRL_CLEAR_BIT    0

// Status register fields
`define STAT_FLAGS_LSB    0
`define STAT_COUNT_LSB    16

// Error register fields, write one to clear
`define ERR_OVERRUN_BIT   0
`define ERR_UNDERRUN_BIT  1
`define ERR_W             2

// Flag geometry and reset value (full, half, near, empty; all active low)
`define NEAR_MARGIN       8
`define FLAGS_RESET       4'hC

// AXI response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== hdl/fifo_pkg.sv
package fifo_pkg;

    // Status flags, every bit active low
    typedef struct packed {
        logic full_low;
        logic half_low;
        logic near_boundary_low;
        logic empty_low;
    } flags_t;

    // AXI write channel sequencing
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

    // AXI read channel sequencing
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;

endpackage

// ===== hdl/fifo_mem.sv
`timescale 1ns/100ps
`default_nettype none

// Simple dual-port storage with registered read data
module fifo_mem #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4096,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic             clk,
    // Write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    // Storage array, no reset so it maps onto block memory
    logic [WIDTH-1:0] mem [DEPTH];

    // Write one word per enabled cycle
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read before write on a shared address
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ===== test/sys_peer.sv
`timescale 1ns/100ps
`default_nettype none

// Writing and reading system logic around the buffer
module sys_peer #(
    parameter int WIDTH = 9
) (
    // Clock
    input  wire logic             aclk,
    // Write side
    output logic                  write_clock,
    output logic                  write_enable_a,
    output logic                  write_enable_b,
    output logic      [WIDTH-1:0] write_data,
    // Read side
    output logic                  read_clock,
    output logic                  read_enable_a,
    output logic                  read_enable_b
);
    // Strobes idle low, data idle as a pattern
    initial begin
        {write_clock, write_enable_a, write_enable_b} = 3'h0;
        {read_clock, read_enable_a, read_enable_b} = 3'h0;
        write_data = '1;
    end

    // One write strobe, enables owned by the caller
    task automatic push(input logic [WIDTH-1:0] d, input logic [1:0] en, input int gap);
        @(posedge aclk);
        {write_clock, write_enable_a, write_enable_b, write_data} <= {1'b1, en, d};
        @(posedge aclk);
        // Released data shows the inverse, not the last word
        {write_clock, write_data} <= {1'b0, ~d};
        repeat (gap) @(posedge aclk);
    endtask

    // One read strobe, enables owned by the caller
    task automatic pop(input logic [1:0] en, input int gap);
        @(posedge aclk);
        {read_clock, read_enable_a, read_enable_b} <= {1'b1, en};
        @(posedge aclk);
        read_clock <= 1'b0;
        repeat (gap) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import fifo_pkg::*;
    localparam int D = 16;
    // Clock, resets and pins
    logic aclk = 1'b0, aresetn = 1'b0, reset_low = 1'b1, output_enable_low = 1'b0;
    logic write_clock, write_enable_a, write_enable_b, read_clock, read_enable_a;
    logic read_enable_b, read_data_drive_low;
    logic [8:0] write_data, read_data, last;
    flags_t flags;
    // AXI4-Lite master side
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    // Bench state
    int bad_count = 0, tests_run = 0, cyc = 0, seed = 96997;
    logic [8:0] q[$];
    // Storage image with free-running pointers, as the device has no interlock
    logic [8:0] ring[D];
    int wp = 0, rp = 0;

    clocked_fifo_4k_x9 #(.DEPTH(D), .WIDTH(9)) clocked_fifo_4k_x9_i (.*);
    sys_peer #(.WIDTH(9)) sys_peer_i (.*);

    always #25 aclk = ~aclk;

    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    // Expected flags for an occupancy
    function automatic flags_t ef(int n);
        return {n != D, n < D / 2 + 1, !(n < 8 || n > D - 8), n != 0};
    endfunction

    task automatic chk(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Register write, both channels offered together
    task automatic axw(input logic [31:0] a, d, output logic [1:0] rs);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    // Register read
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                {d, rs} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    // Random word written, model and flags followed
    task automatic wr(input logic [1:0] en);
        logic [8:0] d;
        d = 9'($random(seed));
        sys_peer_i.push(d, en, 2 + $unsigned($random(seed)) % 3);
        #1;
        if (en == 2'h3 && q.size() == D) q[0] = d;
        else if (en == 2'h3) q.push_back(d);
        if (en == 2'h3) begin
            ring[wp % D] = d;
            wp++;
        end
        chk("flags", ef(q.size()), flags);
    endtask

    // Read, data compared after every strobe, enabled or not
    task automatic rd(input logic [1:0] en);
        sys_peer_i.pop(en, 2 + $unsigned($random(seed)) % 3);
        #1;
        if (en == 2'h3) begin
            // Past empty the read pointer wraps and an old word comes back
            if (q.size() > 0) last = q.pop_front();
            else last = ring[rp % D];
            rp++;
        end
        chk("data", last, read_data);
        chk("flags", ef(q.size()), flags);
    endtask

    initial begin
        last = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk("flags", 32'hC, flags);
        chk("data", 32'h0, read_data);
        axr(32'h4, v, r);
        chk("status", 32'hC, v);
        for (int i = 0; i < 3; i++) wr(2'(i));
        $display("test reset done");
        for (int i = 0; i <= D; i++) wr(2'h3);
        wr({1'b1, flags.full_low});
        axr(32'h8, v, r);
        chk("error", 32'h1, v);
        for (int i = 0; i < D; i++) rd(2'h3);
        rd(2'h2);
        rd({1'b1, flags.empty_low});
        rd(2'h3);
        axr(32'h8, v, r);
        chk("error", 32'h2, v & 32'h2);
        axw(32'h8, 32'h3, r);
        axr(32'h8, v, r);
        chk("error", 32'h0, v);
        $display("test stream done");
        output_enable_low <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("drive", 32'h1, read_data_drive_low);
        output_enable_low <= 1'b0;
        repeat (3) wr(2'h3);
        chk("drive", 32'h0, read_data_drive_low);
        axw(32'h0, 32'h1, r);
        repeat (3) @(posedge aclk);
        #1;
        chk("flags", 32'hC, flags);
        chk("data", 32'h0, read_data);
        q.delete();
        wp = 0;
        rp = 0;
        repeat (2) wr(2'h3);
        rd(2'h3);
        @(posedge aclk);
        reset_low <= 1'b0;
        @(posedge aclk);
        reset_low <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("flags", 32'hC, flags);
        chk("data", 32'h0, read_data);
        $display("test clear done");
        axr(32'hC, v, r);
        chk("rresp", 32'h2, r);
        chk("rdata", 32'h0, v);
        axw(32'hC, 32'h0, r);
        chk("bresp", 32'h2, r);
        $display("test bus done");
        summarize();
    end
endmodule
`default_nettype wire
